// [adz_host_model.sv]
// Host controller model that writes mode control words
`timescale 1ns/100ps
`default_nettype none

module adz_host_model
(
	// Clock
	input  wire logic   clk_i,
	// Control word port
	output logic        ctrl_write_o,
	output logic [15:0] ctrl_word_o
);
	initial
	begin
		ctrl_write_o = 1'b0;
		ctrl_word_o  = 16'h0000;
	end

	// Test bits go out only when the caller asks for a fault; reserved codes are sent as given
	task automatic send(input logic [15:0] w, input bit fault);
		logic [7:0] m;
		case (w[14:8])
			adz_pkg::IDX_OVERSAMPLE: m = adz_pkg::TEST_MASK_OVERSAMPLE;
			adz_pkg::IDX_DEEMPH_OUT: m = adz_pkg::TEST_MASK_DEEMPH_OUT;
			adz_pkg::IDX_FORMAT:     m = adz_pkg::TEST_MASK_FORMAT;
			adz_pkg::IDX_PHASE_FLAG: m = adz_pkg::TEST_MASK_PHASE_FLAG;
			default:                 m = 8'h00;
		endcase
		@(negedge clk_i);
		ctrl_write_o = 1'b1;
		ctrl_word_o  = fault ? w : (w & ~{8'h00, m});
		@(negedge clk_i);
		ctrl_write_o = 1'b0;
		// Stale word is not left on the port after the strobe
		ctrl_word_o  = ~ctrl_word_o;
	endtask
endmodule

`default_nettype wire

// [adz_mode_regs.sv]
// Mode control register bank, audio output path and zero flag outputs
`timescale 1ns/100ps
`default_nettype none

module adz_mode_regs
(
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	// Control word port, one word per strobe
	input  wire logic                  ctrl_write_i,
	input  wire logic [15:0]           ctrl_word_i,
	// Audio samples in, one strobe per word clock period
	input  wire logic                  sample_valid_i,
	input  wire adz_pkg::adz_stereo_t  sample_i,
	// Audio samples out to the modulators
	output logic                       out_valid_o,
	output adz_pkg::adz_stereo_t       out_sample_o,
	// Stored configuration and decoded settings
	output adz_pkg::adz_mode_cfg_t     cfg_o,
	output logic [7:0]                 osr_ratio_o,
	output logic [4:0]                 word_len_o,
	output adz_pkg::adz_kind_t         iface_kind_o,
	output logic [15:0]                deemph_rate_hz_o,
	output logic                       deemph_active_o,
	// Control port status
	output logic                       ctrl_taken_o,
	output logic                       ctrl_ignored_o,
	output logic                       test_bits_set_o,
	// Zero flag pins
	output logic                       left_silence_flag_o,
	output logic                       right_silence_flag_o
);

	logic [7:0]  reg_oversample;
	logic [7:0]  reg_deemph_out;
	logic [7:0]  reg_format;
	logic [7:0]  reg_phase_flag;
	logic [6:0]  word_index;
	logic [7:0]  word_data;
	logic        word_top_bit;
	logic        hit_oversample;
	logic        hit_deemph_out;
	logic        hit_format;
	logic        hit_phase_flag;
	logic        word_code_ok;
	logic        word_accept;
	logic        left_zero;
	logic        right_zero;
	logic        joint_zero;
	logic        next_left_flag;
	logic        next_right_flag;

	// Applies output-off and phase inversion to one channel
	function automatic logic [23:0] chan_out
	(
		input logic [23:0] s,
		input logic        off,
		input logic        inv
	);
		logic [23:0] neg;
		neg = ~s + 24'h000001;
		if (off)
		begin
			chan_out = 24'h000000;
		end
		else if (inv)
		begin
			// Full-scale negative has no positive twin, so clamp instead of wrapping
			if (s == 24'h800000)
			begin
				chan_out = 24'h7fffff;
			end
			else
			begin
				chan_out = neg;
			end
		end
		else
		begin
			chan_out = s;
		end
	endfunction

	// Drives a pin from a detect state and the polarity setting
	function automatic logic flag_level
	(
		input logic detect,
		input logic active_low
	);
		flag_level = detect ^ active_low;
	endfunction

	assign word_top_bit = ctrl_word_i[adz_pkg::CTRL_ZERO_BIT];
	assign word_index   = ctrl_word_i[adz_pkg::IDX_LSB +: adz_pkg::IDX_W];
	assign word_data    = ctrl_word_i[adz_pkg::DATA_W - 1:0];

	// Address decoding of the word index
	always_comb
	begin
		hit_oversample = 1'b0;
		hit_deemph_out = 1'b0;
		hit_format     = 1'b0;
		hit_phase_flag = 1'b0;
		if (word_index == adz_pkg::IDX_OVERSAMPLE)
		begin
			hit_oversample = 1'b1;
		end
		else if (word_index == adz_pkg::IDX_DEEMPH_OUT)
		begin
			hit_deemph_out = 1'b1;
		end
		else if (word_index == adz_pkg::IDX_FORMAT)
		begin
			hit_format = 1'b1;
		end
		else if (word_index == adz_pkg::IDX_PHASE_FLAG)
		begin
			hit_phase_flag = 1'b1;
		end
	end

	// A word carrying a reserved code is dropped whole, keeping the old setting
	always_comb
	begin
		word_code_ok = 1'b1;
		if (hit_deemph_out && word_data[adz_pkg::DEEMPH_RATE_LSB +: 2] == adz_pkg::RATE_RSV)
		begin
			word_code_ok = 1'b0;
		end
		else if (hit_format && word_data[adz_pkg::FMT_LSB +: 3] == adz_pkg::FMT_RSV_6)
		begin
			word_code_ok = 1'b0;
		end
		else if (hit_format && word_data[adz_pkg::FMT_LSB +: 3] == adz_pkg::FMT_RSV_7)
		begin
			word_code_ok = 1'b0;
		end
	end

	assign word_accept = ctrl_write_i && !word_top_bit && word_code_ok &&
	                     (hit_oversample || hit_deemph_out || hit_format || hit_phase_flag);

	// Register storage
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			reg_oversample <= adz_pkg::RST_OVERSAMPLE;
			reg_deemph_out <= adz_pkg::RST_DEEMPH_OUT;
			reg_format     <= adz_pkg::RST_FORMAT;
			reg_phase_flag <= adz_pkg::RST_PHASE_FLAG;
		end
		else if (word_accept)
		begin
			if (hit_oversample)
			begin
				reg_oversample <= word_data;
			end
			else if (hit_deemph_out)
			begin
				reg_deemph_out <= word_data;
			end
			else if (hit_format)
			begin
				reg_format <= word_data;
			end
			else
			begin
				reg_phase_flag <= word_data;
			end
		end
	end

	// Field view of the stored bytes
	always_comb
	begin
		cfg_o.osr_128              = reg_oversample[adz_pkg::OSR_BIT];
		cfg_o.left_output_off      = reg_deemph_out[adz_pkg::LEFT_OFF_BIT];
		cfg_o.right_output_off     = reg_deemph_out[adz_pkg::RIGHT_OFF_BIT];
		cfg_o.deemph_enable        = reg_deemph_out[adz_pkg::DEEMPH_EN_BIT];
		cfg_o.deemph_rate_select   = adz_pkg::adz_rate_t'(reg_deemph_out[adz_pkg::DEEMPH_RATE_LSB +: 2]);
		cfg_o.audio_word_format    = adz_pkg::adz_fmt_t'(reg_format[adz_pkg::FMT_LSB +: 3]);
		cfg_o.filter_rolloff_slow  = reg_format[adz_pkg::ROLLOFF_BIT];
		cfg_o.output_invert        = reg_phase_flag[adz_pkg::INVERT_BIT];
		cfg_o.zero_flag_active_low = reg_phase_flag[adz_pkg::FLAG_POL_BIT];
		cfg_o.zero_flag_combine    = reg_phase_flag[adz_pkg::FLAG_COMB_BIT];
	end

	// Control port status pulses and the test-bit monitor
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_taken_o    <= 1'b0;
			ctrl_ignored_o  <= 1'b0;
			test_bits_set_o <= 1'b0;
		end
		else
		begin
			ctrl_taken_o    <= word_accept;
			ctrl_ignored_o  <= ctrl_write_i && !word_accept;
			// Test bits are stored but steer nothing; a nonzero value is only reported
			test_bits_set_o <= |(reg_oversample & adz_pkg::TEST_MASK_OVERSAMPLE) ||
			                   |(reg_deemph_out & adz_pkg::TEST_MASK_DEEMPH_OUT) ||
			                   |(reg_format & adz_pkg::TEST_MASK_FORMAT) ||
			                   |(reg_phase_flag & adz_pkg::TEST_MASK_PHASE_FLAG);
		end
	end

	// Oversampling ratio for the modulators
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			osr_ratio_o <= adz_pkg::OSR_64;
		end
		else if (cfg_o.osr_128)
		begin
			osr_ratio_o <= adz_pkg::OSR_128;
		end
		else
		begin
			osr_ratio_o <= adz_pkg::OSR_64;
		end
	end

	// Serial audio format decode
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			word_len_o   <= adz_pkg::WORD_LEN_24;
			iface_kind_o <= adz_pkg::KIND_LEFT;
		end
		else
		begin
			case (cfg_o.audio_word_format)
				adz_pkg::FMT_RJ24:
				begin
					word_len_o   <= adz_pkg::WORD_LEN_24;
					iface_kind_o <= adz_pkg::KIND_RIGHT;
				end
				adz_pkg::FMT_RJ20:
				begin
					word_len_o   <= adz_pkg::WORD_LEN_20;
					iface_kind_o <= adz_pkg::KIND_RIGHT;
				end
				adz_pkg::FMT_RJ18:
				begin
					word_len_o   <= adz_pkg::WORD_LEN_18;
					iface_kind_o <= adz_pkg::KIND_RIGHT;
				end
				adz_pkg::FMT_RJ16:
				begin
					word_len_o   <= adz_pkg::WORD_LEN_16;
					iface_kind_o <= adz_pkg::KIND_RIGHT;
				end
				adz_pkg::FMT_I2S:
				begin
					// Length is taken from the frame itself, up to 24 bits
					word_len_o   <= adz_pkg::WORD_LEN_24;
					iface_kind_o <= adz_pkg::KIND_I2S;
				end
				adz_pkg::FMT_LJ:
				begin
					word_len_o   <= adz_pkg::WORD_LEN_24;
					iface_kind_o <= adz_pkg::KIND_LEFT;
				end
				default:
				begin
					word_len_o   <= adz_pkg::WORD_LEN_24;
					iface_kind_o <= adz_pkg::KIND_NONE;
				end
			endcase
		end
	end

	// De-emphasis control for the digital filter
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			deemph_active_o  <= 1'b0;
			deemph_rate_hz_o <= adz_pkg::RATE_44K1_HZ;
		end
		else
		begin
			deemph_active_o <= cfg_o.deemph_enable;
			case (cfg_o.deemph_rate_select)
				adz_pkg::RATE_44K1:
				begin
					deemph_rate_hz_o <= adz_pkg::RATE_44K1_HZ;
				end
				adz_pkg::RATE_48K:
				begin
					deemph_rate_hz_o <= adz_pkg::RATE_48K_HZ;
				end
				adz_pkg::RATE_32K:
				begin
					deemph_rate_hz_o <= adz_pkg::RATE_32K_HZ;
				end
				default:
				begin
					deemph_rate_hz_o <= adz_pkg::RATE_44K1_HZ;
				end
			endcase
		end
	end

	// Output sample path; zero in two's complement is the bipolar mid level
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			out_valid_o  <= 1'b0;
			out_sample_o <= '0;
		end
		else
		begin
			out_valid_o <= sample_valid_i;
			if (sample_valid_i)
			begin
				out_sample_o.left  <= chan_out(sample_i.left, cfg_o.left_output_off, cfg_o.output_invert);
				out_sample_o.right <= chan_out(sample_i.right, cfg_o.right_output_off, cfg_o.output_invert);
			end
		end
	end

	// Zero detection watches the incoming data, not the muted or inverted output
	adz_zero_detect u_left_zero
	(
		.clk_i          (clk_i),
		.rst_n_i        (rst_n_i),
		.sample_valid_i (sample_valid_i),
		.sample_i       (sample_i.left),
		.zero_detect_o  (left_zero)
	);

	adz_zero_detect u_right_zero
	(
		.clk_i          (clk_i),
		.rst_n_i        (rst_n_i),
		.sample_valid_i (sample_valid_i),
		.sample_i       (sample_i.right),
		.zero_detect_o  (right_zero)
	);

	assign joint_zero = left_zero & right_zero;

	// Flag pin routing and polarity
	always_comb
	begin
		if (cfg_o.zero_flag_combine)
		begin
			next_right_flag = flag_level(joint_zero, cfg_o.zero_flag_active_low);
			// The unassigned pin rests at the inactive level
			next_left_flag  = flag_level(1'b0, cfg_o.zero_flag_active_low);
		end
		else
		begin
			next_right_flag = flag_level(right_zero, cfg_o.zero_flag_active_low);
			next_left_flag  = flag_level(left_zero, cfg_o.zero_flag_active_low);
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			left_silence_flag_o  <= 1'b0;
			right_silence_flag_o <= 1'b0;
		end
		else
		begin
			left_silence_flag_o  <= next_left_flag;
			right_silence_flag_o <= next_right_flag;
		end
	end

endmodule

`default_nettype wire

// [adz_mode_regs_asserts.sv]
// Checker for the mode register bank and zero flag outputs
`timescale 1ns/100ps
`default_nettype none

module adz_mode_regs_asserts
(
	// Clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_n_i,
	// Inputs
	input  wire logic                   ctrl_write_i,
	input  wire logic [15:0]            ctrl_word_i,
	input  wire logic                   sample_valid_i,
	input  wire adz_pkg::adz_stereo_t   sample_i,
	// Outputs
	input  wire logic                   out_valid_o,
	input  wire adz_pkg::adz_stereo_t   out_sample_o,
	input  wire adz_pkg::adz_mode_cfg_t cfg_o,
	input  wire logic [7:0]             osr_ratio_o,
	input  wire logic                   deemph_active_o,
	input  wire logic                   ctrl_taken_o,
	input  wire logic                   ctrl_ignored_o,
	input  wire logic                   left_silence_flag_o,
	input  wire logic                   right_silence_flag_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic [10:0] lz_cnt;
	logic [10:0] rz_cnt;
	logic        lz_hit;
	logic        rz_hit;
	logic        l_exp;
	logic        r_exp;

	assign lz_hit = (lz_cnt == adz_pkg::ZERO_RUN_LEN);
	assign rz_hit = (rz_cnt == adz_pkg::ZERO_RUN_LEN);
	assign l_exp  = cfg_o.zero_flag_combine ? cfg_o.zero_flag_active_low : (lz_hit ^ cfg_o.zero_flag_active_low);
	assign r_exp  = (rz_hit & (lz_hit | ~cfg_o.zero_flag_combine)) ^ cfg_o.zero_flag_active_low;

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			lz_cnt <= 11'h000;
		else if (sample_valid_i)
			lz_cnt <= (sample_i.left != 24'h0) ? 11'h000 : (lz_hit ? lz_cnt : lz_cnt + 11'h001);
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			rz_cnt <= 11'h000;
		else if (sample_valid_i)
			rz_cnt <= (sample_i.right != 24'h0) ? 11'h000 : (rz_hit ? rz_cnt : rz_cnt + 11'h001);
	end

	sequence s_good_write;
		ctrl_write_i && !ctrl_word_i[15] && (ctrl_word_i[14:8] == adz_pkg::IDX_PHASE_FLAG);
	endsequence

	sequence s_bad_write;
		ctrl_write_i && (ctrl_word_i[15] || (ctrl_word_i[14:8] == 7'h15)
			|| ((ctrl_word_i[14:8] == adz_pkg::IDX_FORMAT) && (ctrl_word_i[2:1] == 2'b11))
			|| ((ctrl_word_i[14:8] == adz_pkg::IDX_DEEMPH_OUT) && (ctrl_word_i[6:5] == 2'b11)));
	endsequence

	a_write_taken: assert property (s_good_write |=> ctrl_taken_o && !ctrl_ignored_o)
		else $error("accepted word not acknowledged");
	a_reserved_refused: assert property (s_bad_write |=> ctrl_ignored_o && !ctrl_taken_o)
		else $error("refused word not reported");
	a_osr_decode: assert property ($past(rst_n_i) |->
		osr_ratio_o == ($past(cfg_o.osr_128) ? adz_pkg::OSR_128 : adz_pkg::OSR_64))
		else $error("oversampling ratio wrong");
	a_deemph_follow: assert property ($past(rst_n_i) |-> deemph_active_o == $past(cfg_o.deemph_enable))
		else $error("de-emphasis state wrong");
	a_sample_pass: assert property (sample_valid_i && !cfg_o.left_output_off && !cfg_o.output_invert
		|=> out_valid_o && (out_sample_o.left == $past(sample_i.left)))
		else $error("left sample not passed");
	a_off_zero: assert property (sample_valid_i && cfg_o.right_output_off
		|=> out_valid_o ##0 out_sample_o.right == 24'h0)
		else $error("disabled channel not at zero");
	a_left_flag: assert property ($past(rst_n_i) |->
		left_silence_flag_o == $past(l_exp))
		else $error("left flag pin wrong");
	a_right_flag: assert property ($past(rst_n_i) |->
		right_silence_flag_o == $past(r_exp))
		else $error("right flag pin wrong");
endmodule

bind adz_mode_regs adz_mode_regs_asserts u_adz_mode_regs_asserts (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.ctrl_write_i(ctrl_write_i), .ctrl_word_i(ctrl_word_i), .sample_valid_i(sample_valid_i),
	.sample_i(sample_i), .out_valid_o(out_valid_o), .out_sample_o(out_sample_o), .cfg_o(cfg_o),
	.osr_ratio_o(osr_ratio_o), .deemph_active_o(deemph_active_o), .ctrl_taken_o(ctrl_taken_o),
	.ctrl_ignored_o(ctrl_ignored_o), .left_silence_flag_o(left_silence_flag_o),
	.right_silence_flag_o(right_silence_flag_o));

`default_nettype wire

// [adz_pkg.sv]
// Constants, field layouts and carrier types for the audio mode register bank and zero flags
//
// Functional notes
// - Oversampling select bit: 0 gives 64x, 1 gives 128x; resets to 0.
// - Channel output-off bit 0 passes the incoming audio to that channel output.
// - Channel output-off bit 1 holds that output at bipolar zero, ignoring data.
// - De-emphasis enable bit: 0 off (reset), 1 on.
// - De-emphasis rate: 00 44.1 kHz, 01 48 kHz, 10 32 kHz; 11 reserved.
// - Format codes 000..011 select right-justified 24, 20, 18, 16 bits.
// - Format 100 is I2S, 101 left-justified (reset); 110 and 111 reserved.
// - Roll-off bit: 0 sharp (reset), 1 slow interpolation filter response.
// - Invert bit: 0 normal phase, 1 inverted phase on both channels.
// - Flag polarity bit: 0 flags high on zero detect, 1 flags low.
// - Combine bit 0: independent left and right silence flags on their own outputs.
// - Combine bit 1: right output carries a joint flag, left output unassigned.
// - Zero detect per channel after 1024 consecutive zero samples.
// - In zero detect the channel flag reads 1 under default polarity.
`default_nettype none

package adz_pkg;

	// Control word layout
	localparam int CTRL_W          = 16;
	localparam int CTRL_ZERO_BIT   = 15;
	localparam int IDX_LSB         = 8;
	localparam int IDX_W           = 7;
	localparam int DATA_W          = 8;

	// Register indices
	localparam logic [6:0] IDX_OVERSAMPLE  = 7'h12;
	localparam logic [6:0] IDX_DEEMPH_OUT  = 7'h13;
	localparam logic [6:0] IDX_FORMAT      = 7'h14;
	localparam logic [6:0] IDX_PHASE_FLAG  = 7'h16;

	// Field positions inside the data byte
	localparam int OSR_BIT         = 6;
	localparam int LEFT_OFF_BIT    = 0;
	localparam int RIGHT_OFF_BIT   = 1;
	localparam int DEEMPH_EN_BIT   = 4;
	localparam int DEEMPH_RATE_LSB = 5;
	localparam int FMT_LSB         = 0;
	localparam int ROLLOFF_BIT     = 5;
	localparam int INVERT_BIT      = 0;
	localparam int FLAG_POL_BIT    = 1;
	localparam int FLAG_COMB_BIT   = 2;

	// Reset values of the data bytes
	localparam logic [7:0] RST_OVERSAMPLE = 8'h00;
	localparam logic [7:0] RST_DEEMPH_OUT = 8'h00;
	localparam logic [7:0] RST_FORMAT     = 8'h05;
	localparam logic [7:0] RST_PHASE_FLAG = 8'h00;

	// Test-only bit positions of each data byte
	localparam logic [7:0] TEST_MASK_OVERSAMPLE = 8'hbc;
	localparam logic [7:0] TEST_MASK_DEEMPH_OUT = 8'h8c;
	localparam logic [7:0] TEST_MASK_FORMAT     = 8'hd8;
	localparam logic [7:0] TEST_MASK_PHASE_FLAG = 8'hf8;

	// Decoded values
	localparam logic [7:0]  OSR_64        = 8'h40;
	localparam logic [7:0]  OSR_128       = 8'h80;
	localparam logic [4:0]  WORD_LEN_24   = 5'h18;
	localparam logic [4:0]  WORD_LEN_20   = 5'h14;
	localparam logic [4:0]  WORD_LEN_18   = 5'h12;
	localparam logic [4:0]  WORD_LEN_16   = 5'h10;
	localparam logic [15:0] RATE_44K1_HZ  = 16'hac44;
	localparam logic [15:0] RATE_48K_HZ   = 16'hbb80;
	localparam logic [15:0] RATE_32K_HZ   = 16'h7d00;

	// Zero detection
	localparam int          SAMPLE_W      = 24;
	localparam int          ZERO_CNT_W    = 11;
	localparam logic [10:0] ZERO_RUN_LEN  = 11'h400;

	typedef enum logic [2:0] {
		FMT_RJ24  = 3'b000,
		FMT_RJ20  = 3'b001,
		FMT_RJ18  = 3'b010,
		FMT_RJ16  = 3'b011,
		FMT_I2S   = 3'b100,
		FMT_LJ    = 3'b101,
		FMT_RSV_6 = 3'b110,
		FMT_RSV_7 = 3'b111
	} adz_fmt_t;

	typedef enum logic [1:0] {
		RATE_44K1 = 2'b00,
		RATE_48K  = 2'b01,
		RATE_32K  = 2'b10,
		RATE_RSV  = 2'b11
	} adz_rate_t;

	typedef enum logic [1:0] {
		KIND_RIGHT = 2'b00,
		KIND_I2S   = 2'b01,
		KIND_LEFT  = 2'b10,
		KIND_NONE  = 2'b11
	} adz_kind_t;

	typedef struct packed {
		logic      osr_128;
		logic      left_output_off;
		logic      right_output_off;
		logic      deemph_enable;
		adz_rate_t deemph_rate_select;
		adz_fmt_t  audio_word_format;
		logic      filter_rolloff_slow;
		logic      output_invert;
		logic      zero_flag_active_low;
		logic      zero_flag_combine;
	} adz_mode_cfg_t;

	typedef struct packed {
		logic [23:0] left;
		logic [23:0] right;
	} adz_stereo_t;

endpackage

`default_nettype wire

// [adz_zero_detect.sv]
// Per-channel run counter of consecutive zero samples
`timescale 1ns/100ps
`default_nettype none

module adz_zero_detect
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// Sample stream, one strobe per word clock period
	input  wire logic        sample_valid_i,
	input  wire logic [23:0] sample_i,
	// Detect state
	output logic             zero_detect_o
);

	logic [10:0] run_cnt;

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			run_cnt       <= 11'h000;
			zero_detect_o <= 1'b0;
		end
		else if (sample_valid_i)
		begin
			if (sample_i != 24'h000000)
			begin
				run_cnt       <= 11'h000;
				zero_detect_o <= 1'b0;
			end
			else if (run_cnt != adz_pkg::ZERO_RUN_LEN)
			begin
				// Saturates so a long silence never wraps back out of detect
				run_cnt <= run_cnt + 11'h001;
				if (run_cnt == adz_pkg::ZERO_RUN_LEN - 11'h001)
				begin
					zero_detect_o <= 1'b1;
				end
			end
		end
	end

endmodule

`default_nettype wire

// [audio_dac_mode_regs_zero_flags_tb.sv]
// Self-checking testbench for the mode register bank and zero flags
`timescale 1ns/100ps
`default_nettype none

module audio_dac_mode_regs_zero_flags_tb;
	logic                   clk;
	logic                   rst_n;
	logic                   ctrl_write;
	logic [15:0]            ctrl_word;
	logic                   sample_valid;
	adz_pkg::adz_stereo_t   sample;
	logic                   out_valid_o;
	adz_pkg::adz_stereo_t   out_sample_o;
	adz_pkg::adz_mode_cfg_t cfg_o;
	logic [7:0]             osr_ratio_o;
	logic [4:0]             word_len_o;
	adz_pkg::adz_kind_t     iface_kind_o;
	logic [15:0]            deemph_rate_hz_o;
	logic                   deemph_active_o;
	logic                   ctrl_taken_o;
	logic                   ctrl_ignored_o;
	logic                   test_bits_set_o;
	logic                   lflag;
	logic                   rflag;
	int                     fail_count = 0;
	int                     n_checks = 0;

	adz_host_model u_adz_host_model (.clk_i(clk), .ctrl_write_o(ctrl_write), .ctrl_word_o(ctrl_word));

	adz_mode_regs u_adz_mode_regs (.clk_i(clk), .rst_n_i(rst_n), .ctrl_write_i(ctrl_write),
		.ctrl_word_i(ctrl_word), .sample_valid_i(sample_valid), .sample_i(sample),
		.out_valid_o(out_valid_o), .out_sample_o(out_sample_o), .cfg_o(cfg_o), .osr_ratio_o(osr_ratio_o),
		.word_len_o(word_len_o), .iface_kind_o(iface_kind_o), .deemph_rate_hz_o(deemph_rate_hz_o),
		.deemph_active_o(deemph_active_o), .ctrl_taken_o(ctrl_taken_o), .ctrl_ignored_o(ctrl_ignored_o),
		.test_bits_set_o(test_bits_set_o), .left_silence_flag_o(lflag), .right_silence_flag_o(rflag));

	always #10 clk = ~clk;

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results;
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Decoded outputs settle one edge after the stored byte, hence the extra cycle
	task automatic wr(input logic [15:0] w, input bit fault, input bit refuse);
		u_adz_host_model.send(w, fault);
		check(ctrl_taken_o, !refuse);
		check(ctrl_ignored_o, refuse);
		@(negedge clk);
	endtask

	task automatic feed(input logic [23:0] l, input logic [23:0] r, input int n);
		@(negedge clk);
		sample_valid = 1'b1;
		sample = {l, r};
		repeat (n) @(negedge clk);
		sample_valid = 1'b0;
	endtask

	task automatic t_reset;
		adz_pkg::adz_mode_cfg_t e;
		e = '0;
		e.audio_word_format = adz_pkg::FMT_LJ;
		check(cfg_o, e);
		check(osr_ratio_o, adz_pkg::OSR_64);
		check(iface_kind_o, adz_pkg::KIND_LEFT);
		check(deemph_rate_hz_o, adz_pkg::RATE_44K1_HZ);
		check({lflag, rflag}, 2'b00);
		wr(16'h9601, 1'b1, 1'b1);
		wr(16'h1501, 1'b1, 1'b1);
		check(cfg_o.output_invert, 1'b0);
		wr(16'h16f8, 1'b0, 1'b0);
		check(test_bits_set_o, 1'b0);
		wr(16'h1680, 1'b1, 1'b0);
		check(test_bits_set_o, 1'b1);
		wr(16'h1600, 1'b0, 1'b0);
		check(test_bits_set_o, 1'b0);
	endtask

	task automatic t_osr;
		wr(16'h1240, 1'b0, 1'b0);
		check(osr_ratio_o, adz_pkg::OSR_128);
		wr(16'h1200, 1'b0, 1'b0);
		check(osr_ratio_o, adz_pkg::OSR_64);
	endtask

	task automatic t_format;
		logic [4:0]         len [6];
		adz_pkg::adz_kind_t kind [6];
		len = '{adz_pkg::WORD_LEN_24, adz_pkg::WORD_LEN_20, adz_pkg::WORD_LEN_18, adz_pkg::WORD_LEN_16,
			adz_pkg::WORD_LEN_24, adz_pkg::WORD_LEN_24};
		kind = '{adz_pkg::KIND_RIGHT, adz_pkg::KIND_RIGHT, adz_pkg::KIND_RIGHT, adz_pkg::KIND_RIGHT,
			adz_pkg::KIND_I2S, adz_pkg::KIND_LEFT};
		for (int i = 0; i < 6; i++)
		begin
			wr({13'h0280, 3'(i)}, 1'b0, 1'b0);
			check(word_len_o, len[i]);
			check(iface_kind_o, kind[i]);
		end
		wr(16'h1426, 1'b1, 1'b1);
		wr(16'h1427, 1'b1, 1'b1);
		wr(16'h1425, 1'b0, 1'b0);
		check(cfg_o.filter_rolloff_slow, 1'b1);
		check(cfg_o.audio_word_format, adz_pkg::FMT_LJ);
	endtask

	task automatic t_deemph;
		logic [15:0] hz [3];
		hz = '{adz_pkg::RATE_44K1_HZ, adz_pkg::RATE_48K_HZ, adz_pkg::RATE_32K_HZ};
		for (int r = 0; r < 3; r++)
		begin
			wr({9'h026, 2'(r), 5'h10}, 1'b0, 1'b0);
			check(deemph_rate_hz_o, hz[r]);
			check(deemph_active_o, 1'b1);
		end
		wr(16'h1370, 1'b1, 1'b1);
		check(deemph_rate_hz_o, adz_pkg::RATE_32K_HZ);
		wr(16'h1300, 1'b0, 1'b0);
		check(deemph_active_o, 1'b0);
	endtask

	task automatic t_output;
		feed(24'h000010, 24'h123456, 1);
		check(out_valid_o, 1'b1);
		check(out_sample_o, 48'h000010123456);
		wr(16'h1301, 1'b0, 1'b0);
		feed(24'h000010, 24'h123456, 1);
		check(out_sample_o, 48'h000000123456);
		wr(16'h1302, 1'b0, 1'b0);
		feed(24'h000010, 24'h123456, 1);
		check(out_sample_o, 48'h000010000000);
		wr(16'h1300, 1'b0, 1'b0);
		wr(16'h1601, 1'b0, 1'b0);
		feed(24'h000010, 24'h800000, 1);
		check(out_sample_o, 48'hfffff07fffff);
		wr(16'h1600, 1'b0, 1'b0);
	endtask

	task automatic t_zero;
		feed(24'h0, 24'h1, 1023);
		@(negedge clk);
		check({lflag, rflag}, 2'b00);
		feed(24'h0, 24'h1, 1);
		@(negedge clk);
		check({lflag, rflag}, 2'b10);
		wr(16'h1602, 1'b0, 1'b0);
		check({lflag, rflag}, 2'b01);
		feed(24'h5, 24'h1, 1);
		@(negedge clk);
		check({lflag, rflag}, 2'b11);
		wr(16'h1604, 1'b0, 1'b0);
		feed(24'h0, 24'h0, 1024);
		@(negedge clk);
		check({lflag, rflag}, 2'b01);
		feed(24'h0, 24'h7, 1);
		@(negedge clk);
		check({lflag, rflag}, 2'b00);
		wr(16'h1600, 1'b0, 1'b0);
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		fail_count++;
		results();
	end

	initial
	begin
		clk = 1'b0;
		rst_n = 1'b0;
		sample_valid = 1'b0;
		sample = '0;
		repeat (12) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_osr();
		t_format();
		t_deemph();
		t_output();
		t_zero();
		results();
	end
endmodule

`default_nettype wire
